// ==== aicr_pkg.sv ====
// package for the converter input and lane configuration register slice
package aicr_pkg;
    // register addresses on the serial control port (byte wide registers)
    localparam logic [14:0] ADDR_FS_B_LSB   = 15'h0032;
    localparam logic [14:0] ADDR_FS_B_MSB   = 15'h0033;
    localparam logic [14:0] ADDR_REF_BYPASS = 15'h0038;
    localparam logic [14:0] ADDR_TIMESTAMP_INPUT_CONTROL = 15'h003B;
    localparam logic [14:0] ADDR_PREEMPH    = 15'h0048;
    localparam logic [14:0] ADDR_INPUT_SEL  = 15'h0060;
    localparam logic [14:0] ADDR_CAL_EN     = 15'h0061;

    // reset values
    localparam logic [15:0] RST_FS_B        = 16'hA000;
    localparam logic [7:0]  RST_REF_BYPASS  = 8'h00;
    localparam logic [7:0]  RST_TIMESTAMP_INPUT_CONTROL  = 8'h00;
    localparam logic [7:0]  RST_PREEMPH     = 8'h00;
    localparam logic [7:0]  RST_INPUT_SEL   = 8'h01;
    localparam logic [7:0]  RST_CAL_EN      = 8'h01;

    // writable bit masks; reserved bits hold zero
    localparam logic [7:0]  MSK_REF_BYPASS  = 8'h01;
    localparam logic [7:0]  MSK_TIMESTAMP_INPUT_CONTROL  = 8'h03;
    localparam logic [7:0]  MSK_PREEMPH     = 8'h0F;
    localparam logic [7:0]  MSK_INPUT_SEL   = 8'h13;
    localparam logic [7:0]  MSK_CAL_EN      = 8'h01;

    // field positions
    localparam int BIT_REF_BYPASS  = 0;
    localparam int BIT_TS_RECV_EN  = 0;
    localparam int BIT_TS_LVPECL   = 1;
    localparam int BIT_PE_BOOST    = 3;
    localparam int BIT_DUAL_SWAP   = 4;
    localparam int BIT_CAL_EN      = 0;

    // single-input select encodings
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_FIRST    = 2'h1;
    localparam logic [1:0] SEL_SECOND   = 2'h2;
    localparam logic [1:0] SEL_DUAL_DES = 2'h3;

    // routing applied to the converter channels
    typedef struct packed {
        logic chan_a_second;  // channel a samples the second input
        logic chan_b_second;  // channel b samples the second input
        logic chan_b_active;  // channel b converts
    } aicr_route_t;

    localparam aicr_route_t RST_ROUTE = '{chan_a_second: 1'b0, chan_b_second: 1'b1,
                                          chan_b_active: 1'b0};

    // request port of the serial control interface
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } aicr_req_t;

    // controls presented to the analog and serializer blocks
    typedef struct packed {
        logic [15:0] second_input_fullscale;
        logic        reference_bypass;
        logic        timestamp_receiver_enable;
        logic        timestamp_low_voltage_pecl;
        logic [2:0]  lane_preemphasis_level;
        logic        lane_preemphasis_boost;
        logic        calibration_enable;
        logic        divider_reset;
    } aicr_ctrl_t;

    typedef struct packed {
        logic [15:0] fs_b;
        logic [7:0]  ref_bypass;
        logic [7:0]  timestamp_input_control;
        logic [7:0]  preemph;
        logic [7:0]  input_sel;
        logic [7:0]  cal_en;
        logic        cal_en_d;
        aicr_route_t route;
        logic [7:0]  rdata;
        logic        rvalid;
    } aicr_state_t;
endpackage

// ==== aicr_regs.sv ====
// configuration register slice: full-scale, reference, timestamp, pre-emphasis, input mux
`timescale 1ns/1ps
`default_nettype none

module aicr_regs (
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_RESET_N,
    input  wire logic                I_CLK_EN,
    input  wire aicr_pkg::aicr_req_t I_REQ,
    input  wire logic                I_SINGLE_CHANNEL_MODE,
    output logic [7:0]               O_RDATA,
    output logic                     O_RVALID,
    output aicr_pkg::aicr_ctrl_t     O_CTRL,
    output aicr_pkg::aicr_route_t    O_ROUTE
);

    aicr_pkg::aicr_state_t st_ff;
    aicr_pkg::aicr_state_t nxt_st;

    // routing derived from the mux fields and the operating mode class
    function automatic aicr_pkg::aicr_route_t calc_route(
        input logic [7:0]          sel,
        input logic                single_mode,
        input aicr_pkg::aicr_route_t prev
    );
        aicr_pkg::aicr_route_t r;
        r = prev;
        if (single_mode) begin
            // swap bit plays no part here
            case (sel[1:0])
                aicr_pkg::SEL_FIRST: begin
                    r = '{chan_a_second: 1'b0, chan_b_second: 1'b0, chan_b_active: 1'b0};
                end
                aicr_pkg::SEL_SECOND: begin
                    r = '{chan_a_second: 1'b1, chan_b_second: 1'b1, chan_b_active: 1'b0};
                end
                aicr_pkg::SEL_DUAL_DES: begin
                    r = '{chan_a_second: 1'b0, chan_b_second: 1'b1, chan_b_active: 1'b1};
                end
                default: begin
                    // reserved code keeps whatever routing was in force
                    r = prev;
                end
            endcase
        end else begin
            // single-input field ignored in dual modes
            r.chan_a_second = sel[aicr_pkg::BIT_DUAL_SWAP];
            r.chan_b_second = ~sel[aicr_pkg::BIT_DUAL_SWAP];
            r.chan_b_active = 1'b1;
        end
        return r;
    endfunction

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.cal_en_d = st_ff.cal_en[aicr_pkg::BIT_CAL_EN];
        if (I_REQ.wr) begin
            // reserved bits are masked so they always read zero
            case (I_REQ.addr)
                aicr_pkg::ADDR_FS_B_LSB: begin
                    nxt_st.fs_b[7:0] = I_REQ.wdata;
                end
                aicr_pkg::ADDR_FS_B_MSB: begin
                    nxt_st.fs_b[15:8] = I_REQ.wdata;
                end
                aicr_pkg::ADDR_REF_BYPASS: begin
                    nxt_st.ref_bypass = I_REQ.wdata & aicr_pkg::MSK_REF_BYPASS;
                end
                aicr_pkg::ADDR_TIMESTAMP_INPUT_CONTROL: begin
                    nxt_st.timestamp_input_control = I_REQ.wdata & aicr_pkg::MSK_TIMESTAMP_INPUT_CONTROL;
                end
                aicr_pkg::ADDR_PREEMPH: begin
                    nxt_st.preemph = I_REQ.wdata & aicr_pkg::MSK_PREEMPH;
                end
                aicr_pkg::ADDR_INPUT_SEL: begin
                    nxt_st.input_sel = I_REQ.wdata & aicr_pkg::MSK_INPUT_SEL;
                end
                aicr_pkg::ADDR_CAL_EN: begin
                    nxt_st.cal_en = I_REQ.wdata & aicr_pkg::MSK_CAL_EN;
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        // routing is latched only on the rising edge of calibration enable,
        // so a mux change stays dormant until calibration is rerun
        if (st_ff.cal_en[aicr_pkg::BIT_CAL_EN] && !st_ff.cal_en_d) begin
            nxt_st.route = calc_route(st_ff.input_sel, I_SINGLE_CHANNEL_MODE, st_ff.route);
        end
        if (I_REQ.rd) begin
            nxt_st.rvalid = 1'b1;
            case (I_REQ.addr)
                aicr_pkg::ADDR_FS_B_LSB:   nxt_st.rdata = st_ff.fs_b[7:0];
                aicr_pkg::ADDR_FS_B_MSB:   nxt_st.rdata = st_ff.fs_b[15:8];
                aicr_pkg::ADDR_REF_BYPASS: nxt_st.rdata = st_ff.ref_bypass;
                aicr_pkg::ADDR_TIMESTAMP_INPUT_CONTROL: nxt_st.rdata = st_ff.timestamp_input_control;
                aicr_pkg::ADDR_PREEMPH:    nxt_st.rdata = st_ff.preemph;
                aicr_pkg::ADDR_INPUT_SEL:  nxt_st.rdata = st_ff.input_sel;
                aicr_pkg::ADDR_CAL_EN:     nxt_st.rdata = st_ff.cal_en;
                default:                   nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_ff.fs_b       <= aicr_pkg::RST_FS_B;
            st_ff.ref_bypass <= aicr_pkg::RST_REF_BYPASS;
            st_ff.timestamp_input_control <= aicr_pkg::RST_TIMESTAMP_INPUT_CONTROL;
            st_ff.preemph    <= aicr_pkg::RST_PREEMPH;
            st_ff.input_sel  <= aicr_pkg::RST_INPUT_SEL;
            st_ff.cal_en     <= aicr_pkg::RST_CAL_EN;
            // marked as already enabled so no spurious latch after reset
            st_ff.cal_en_d   <= 1'b1;
            st_ff.route      <= aicr_pkg::RST_ROUTE;
            st_ff.rdata      <= 8'h00;
            st_ff.rvalid     <= 1'b0;
        end else if (I_CLK_EN) begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        O_RDATA  = st_ff.rdata;
        O_RVALID = st_ff.rvalid;
        O_ROUTE  = st_ff.route;
        O_CTRL.second_input_fullscale     = st_ff.fs_b;
        O_CTRL.reference_bypass           = st_ff.ref_bypass[aicr_pkg::BIT_REF_BYPASS];
        O_CTRL.timestamp_receiver_enable  = st_ff.timestamp_input_control[aicr_pkg::BIT_TS_RECV_EN];
        O_CTRL.timestamp_low_voltage_pecl = st_ff.timestamp_input_control[aicr_pkg::BIT_TS_LVPECL];
        O_CTRL.lane_preemphasis_level     = st_ff.preemph[2:0];
        O_CTRL.lane_preemphasis_boost     = st_ff.preemph[aicr_pkg::BIT_PE_BOOST];
        O_CTRL.calibration_enable         = st_ff.cal_en[aicr_pkg::BIT_CAL_EN];
        O_CTRL.divider_reset              = ~st_ff.cal_en[aicr_pkg::BIT_CAL_EN];
    end

endmodule // aicr_regs

`default_nettype wire

// ==== aicr_regs_props.sv ====
// assertions on the configuration register slice ports
`timescale 1ns/1ps
`default_nettype none
module aicr_regs_chk (
    input wire logic                  I_CLK_SYS,
    input wire logic                  I_RESET_N,
    input wire logic                  I_CLK_EN,
    input wire aicr_pkg::aicr_req_t   I_REQ,
    input wire logic                  I_SINGLE_CHANNEL_MODE,
    input wire logic [7:0]            O_RDATA,
    input wire logic                  O_RVALID,
    input wire aicr_pkg::aicr_ctrl_t  O_CTRL,
    input wire aicr_pkg::aicr_route_t O_ROUTE
);
    wire logic w = I_CLK_EN & I_REQ.wr;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    property p_rd; I_CLK_EN && I_REQ.rd |=> O_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_no_rd; !(I_CLK_EN && I_REQ.rd) |=> !O_RVALID; endproperty
    a_no_rd: assert property (p_no_rd) else $error("unrequested read data");
    property p_fs; w && I_REQ.addr == aicr_pkg::ADDR_FS_B_MSB
        |=> O_CTRL.second_input_fullscale[15:8] == $past(I_REQ.wdata); endproperty
    a_fs: assert property (p_fs) else $error("full scale high byte lost");
    property p_byp; w && I_REQ.addr == aicr_pkg::ADDR_REF_BYPASS
        |=> O_CTRL.reference_bypass == $past(I_REQ.wdata[0]); endproperty
    a_byp: assert property (p_byp) else $error("reference bypass wrong");
    property p_ts; w && I_REQ.addr == aicr_pkg::ADDR_TIMESTAMP_INPUT_CONTROL
        |=> {O_CTRL.timestamp_low_voltage_pecl, O_CTRL.timestamp_receiver_enable}
            == $past(I_REQ.wdata[1:0]);
    endproperty
    a_ts: assert property (p_ts) else $error("timestamp control wrong");
    property p_pe; w && I_REQ.addr == aicr_pkg::ADDR_PREEMPH |=> {O_CTRL.lane_preemphasis_boost,
        O_CTRL.lane_preemphasis_level} == $past(I_REQ.wdata[3:0]); endproperty
    a_pe: assert property (p_pe) else $error("pre-emphasis wrong");
    property p_div; O_CTRL.divider_reset != O_CTRL.calibration_enable; endproperty
    a_div: assert property (p_div) else $error("divider reset not tied");
    property p_route; !$rose(O_CTRL.calibration_enable) |=> $stable(O_ROUTE); endproperty
    a_route: assert property (p_route) else $error("route moved without calibration");
    property p_dual; $rose(O_CTRL.calibration_enable) && !I_SINGLE_CHANNEL_MODE
        |=> O_ROUTE.chan_b_active; endproperty
    a_dual: assert property (p_dual) else $error("dual mode channel b idle");
    property p_frz; !I_CLK_EN |=> $stable(O_CTRL); endproperty
    a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule // aicr_regs_chk
bind aicr_regs aicr_regs_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N),
    .I_CLK_EN(I_CLK_EN), .I_REQ(I_REQ), .I_SINGLE_CHANNEL_MODE(I_SINGLE_CHANNEL_MODE),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_CTRL(O_CTRL), .O_ROUTE(O_ROUTE));
`default_nettype wire

// ==== aicr_host.sv ====
// host model issuing control port requests to the register slice
`timescale 1ns/1ps
`default_nettype none
module aicr_host (
    input  wire logic          i_clk,
    input  wire logic [7:0]    i_rdata,
    input  wire logic          i_rvalid,
    output var aicr_pkg::aicr_req_t o_req
);
    initial o_req = '0;
    // released fields show the inverse so stale values never pass for a match
    task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge i_clk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = i_rvalid ? i_rdata : 8'hXX;
    endtask
    task automatic recal();
        logic [7:0] q;
        xfer(1'b1, aicr_pkg::ADDR_CAL_EN, 8'h00, q);
        xfer(1'b1, aicr_pkg::ADDR_CAL_EN, 8'h01, q);
    endtask
endmodule // aicr_host
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {logic [14:0] a; logic [7:0] d, rst, exp;} aicr_row_t;
    // full scale rows keep the host inside the recommended range
    localparam aicr_row_t ROWS [8] = '{'{aicr_pkg::ADDR_FS_B_LSB, 8'h3C, 8'h00, 8'h3C},
        '{aicr_pkg::ADDR_FS_B_MSB, 8'h5A, 8'hA0, 8'h5A}, '{aicr_pkg::ADDR_REF_BYPASS, 8'hFF,
        8'h00, 8'h01}, '{aicr_pkg::ADDR_TIMESTAMP_INPUT_CONTROL, 8'hFF, 8'h00, 8'h03}, '{aicr_pkg::ADDR_PREEMPH,
        8'hFF, 8'h00, 8'h0F}, '{aicr_pkg::ADDR_INPUT_SEL, 8'hEE, 8'h01, 8'h02},
        '{aicr_pkg::ADDR_CAL_EN, 8'hFE, 8'h01, 8'h00}, '{15'h007F, 8'hFF, 8'h00, 8'h00}};
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, single = 1'b1, rvalid;
    logic [7:0] rdata, q;
    aicr_pkg::aicr_req_t req;
    aicr_pkg::aicr_ctrl_t ctrl;
    aicr_pkg::aicr_route_t route;
    int errors = 0, comparisons = 0, cyc = 0;
    always #10 clk = ~clk;
    aicr_regs u_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CLK_EN(en), .I_REQ(req),
        .I_SINGLE_CHANNEL_MODE(single), .O_RDATA(rdata), .O_RVALID(rvalid), .O_CTRL(ctrl),
        .O_ROUTE(route));
    aicr_host u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            u_host.xfer(1'b0, ROWS[i].a, 8'h00, q);
            chk({8'h00, q}, {8'h00, ROWS[i].rst});
            u_host.xfer(1'b1, ROWS[i].a, ROWS[i].d, q);
            u_host.xfer(1'b0, ROWS[i].a, 8'h00, q);
            chk({8'h00, q}, {8'h00, ROWS[i].exp});
        end
        chk(ctrl.second_input_fullscale, 16'h5A3C);
        chk(16'(ctrl.divider_reset), 16'h0001);
        chk(16'(route), 16'(aicr_pkg::RST_ROUTE));
        $display("test register table done");
        u_host.recal();
        settle();
        chk(16'({route.chan_a_second, route.chan_b_active}), 16'h0002);
        single = 1'b0;
        u_host.xfer(1'b1, aicr_pkg::ADDR_INPUT_SEL, 8'h13, q);
        u_host.recal();
        settle();
        chk(16'(route), 16'h0005);
        single = 1'b1;
        u_host.recal();
        settle();
        chk(16'(route), 16'h0003);
        u_host.xfer(1'b1, aicr_pkg::ADDR_INPUT_SEL, 8'h01, q);
        u_host.recal();
        settle();
        chk(16'(route), 16'h0000);
        en = 1'b0;
        u_host.xfer(1'b1, aicr_pkg::ADDR_PREEMPH, 8'h00, q);
        en = 1'b1;
        chk(16'({ctrl.lane_preemphasis_boost, ctrl.lane_preemphasis_level}), 16'h000F);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk(ctrl.second_input_fullscale, aicr_pkg::RST_FS_B);
        chk(16'(route), 16'(aicr_pkg::RST_ROUTE));
        $display("test routing and reset done");
        tally_and_finish();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            tally_and_finish();
        end
    end
endmodule // testbench
`default_nettype wire
